// ---- src/pps_loop_ctrl.sv ----
// Loop path selection, bandwidth, damping and phase detector control.
//
// Behaviour
// - Second multiplier input bit low: feed from secondary loop at selected frequency.
// - Second multiplier input bit high: low-rate synthesizer, rate from two-bit code.
// - First multiplier codes 000/001: primary loop 77.76 MHz, analog or digital feedback.
// - First multiplier codes 010-101: low-rate synthesizer 12E1, 16E1, 24DS1, 16DS1.
// - First multiplier can never take the secondary loop output.
// - After reset the primary loop uses analog feedback.
// - Port ratio selects; first multiplier /1,/2 differential only, /48 single-ended only.
// - Comparator error is averaged by a 100 Hz low-pass before the loop filter.
// - Acquisition bandwidth selectable 18, 35 or 70 Hz, 70 Hz at reset.
// - Locked bandwidth selectable 18, 35 or 70 Hz.
// - Damping codes map to 1.2, 2.5, 5, 10, 20 per bandwidth table.
// - Default damping yields about 0.1 dB gain peak.
// - References above 77.76 MHz are halved before comparison when divide-to-8k is off.
// - Divide-to-8k bit in per-input config divides reference to 8 kHz.
// - Full-cycle capture until lock; nearest-edge after lock when wide detector off.
// - Wide detector enable bit and four-bit range from 0 to 8191 UI.
// - Wide-use bit feeds multi-cycle phase when the wide detector is enabled; else detector error passes unclamped.
// - Four separately enabled phase loss sources.
// - Lock state picks capture mode and acquisition or locked bandwidth.
// - Detector balance registers 6A, 6C, 6D are plain settings with working defaults; 6B holds the damping code.
`timescale 1ns/1ps
`default_nettype none
module pps_loop_ctrl #(
   parameter int ERR_W = 16,
   parameter int DIV_W = 16
) (
   // Clock and reset.
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   // Register port.
   input  wire logic [7:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [7:0]       reg_rdata,
   // Reference and detector inputs from the loop datapath.
   input  wire logic [2:0]       active_input,
   input  wire logic             ref_edge,
   input  wire logic             ref_is_155m,
   input  wire logic [DIV_W-1:0] ref_div_ratio,
   input  wire logic             err_valid,
   input  wire logic [ERR_W-1:0] pfd_error,
   input  wire logic [ERR_W-1:0] wide_phase,
   input  wire logic             fine_loss,
   input  wire logic             coarse_slip,
   input  wire logic             at_freq_limit,
   input  wire logic             input_idle,
   // Loop configuration outputs.
   output pps_pkg::pps_src_e     mux1_src,
   output pps_pkg::pps_src_e     mux2_src,
   output logic [2:0]            sec_freq_code,
   output logic                  digital_feedback,
   output logic [3:0]            port1_ratio,
   output logic [3:0]            port2_ratio,
   output logic [1:0]            active_bw,
   output pps_pkg::pps_damp_t    damping,
   output pps_pkg::pps_capture_e capture_mode,
   output logic                  ref_compare_edge,
   output logic [ERR_W-1:0]      loop_error,
   output logic [12:0]           wide_range_ui,
   output logic                  phase_lost
);
   logic [7:0] mux_sel;
   logic [7:0] sec_freq;
   logic [7:0] lock_bw;
   logic [7:0] acq_bw;
   logic [7:0] pd_bal [4];
   logic [7:0] loss_cfg;
   logic [7:0] wide_cfg;
   logic [7:0] port_sel [2];
   logic [7:0] in_cfg [7];
   logic       lost_q;
   logic       half_toggle;
   logic       div8k_edge;
   logic       div8k_on;
   logic [ERR_W-1:0] avg_err;
   logic [ERR_W-1:0] sel_err;
   logic [2:0]       in_idx;

   function automatic pps_pkg::pps_src_e rate_src(input logic [1:0] code);
      case (code)
         2'h0:    rate_src = pps_pkg::PPS_SRC_12E1;
         2'h1:    rate_src = pps_pkg::PPS_SRC_16E1;
         2'h2:    rate_src = pps_pkg::PPS_SRC_24DS1;
         default: rate_src = pps_pkg::PPS_SRC_16DS1;
      endcase
   endfunction

   function automatic logic [1:0] bw_code(input logic [7:0] r);
      bw_code = (r[1:0] > pps_pkg::BW_70HZ) ? pps_pkg::BW_70HZ : r[1:0];
   endfunction

   function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                     input logic [7:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // Register writes.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         mux_sel  <= pps_pkg::RST_MUX_SEL;
         sec_freq <= pps_pkg::RST_SEC_FREQ;
         lock_bw  <= pps_pkg::RST_LOCK_BW;
         acq_bw   <= pps_pkg::RST_ACQ_BW;
         loss_cfg <= pps_pkg::RST_LOSS_CFG;
         wide_cfg <= pps_pkg::RST_WIDE_CFG;
      end else if (reg_wr) begin
         case (reg_addr)
            pps_pkg::ADDR_MUX_SEL:  mux_sel  <= reg_wdata;
            pps_pkg::ADDR_SEC_FREQ: sec_freq <= reg_wdata;
            pps_pkg::ADDR_LOCK_BW:  lock_bw  <= reg_wdata;
            pps_pkg::ADDR_ACQ_BW:   acq_bw   <= reg_wdata;
            pps_pkg::ADDR_LOSS_CFG: loss_cfg <= reg_wdata;
            pps_pkg::ADDR_WIDE_CFG: wide_cfg <= reg_wdata;
            default: ;
         endcase
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_bal
         always_ff @(posedge sys_clk) begin
            if (!reset_n) begin
               pd_bal[gi] <= (gi == 1) ? pps_pkg::RST_DAMPING : pps_pkg::RST_PD_BAL;
            end else if (reg_wr && reg_addr == pps_pkg::ADDR_PD_BAL_FIRST + 8'(gi)) begin
               pd_bal[gi] <= reg_wdata;
            end
         end
      end
      for (gi = 0; gi < 2; gi++) begin : g_port
         always_ff @(posedge sys_clk) begin
            if (!reset_n) begin
               port_sel[gi] <= pps_pkg::RST_PORT_SEL;
            end else if (reg_wr && reg_addr == pps_pkg::ADDR_PORT1_SEL + 8'(gi)) begin
               port_sel[gi] <= reg_wdata;
            end
         end
      end
      for (gi = 0; gi < 7; gi++) begin : g_in
         always_ff @(posedge sys_clk) begin
            if (!reset_n) begin
               in_cfg[gi] <= pps_pkg::RST_IN_CFG;
            end else if (reg_wr && reg_addr == pps_pkg::ADDR_IN_CFG_FIRST + 8'(gi)) begin
               in_cfg[gi] <= reg_wdata;
            end
         end
      end
   endgenerate

   // Register reads, data one cycle after the strobe; unmapped reads return zero.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (in_range(reg_addr, pps_pkg::ADDR_IN_CFG_FIRST, pps_pkg::ADDR_IN_CFG_LAST)) begin
            reg_rdata <= in_cfg[3'(reg_addr - pps_pkg::ADDR_IN_CFG_FIRST)];
         end else if (in_range(reg_addr, pps_pkg::ADDR_PD_BAL_FIRST,
                               pps_pkg::ADDR_PD_BAL_LAST)) begin
            reg_rdata <= pd_bal[2'(reg_addr - pps_pkg::ADDR_PD_BAL_FIRST)];
         end else begin
            case (reg_addr)
               pps_pkg::ADDR_PORT1_SEL: reg_rdata <= port_sel[0];
               pps_pkg::ADDR_PORT2_SEL: reg_rdata <= port_sel[1];
               pps_pkg::ADDR_MUX_SEL:   reg_rdata <= mux_sel;
               pps_pkg::ADDR_SEC_FREQ:  reg_rdata <= sec_freq;
               pps_pkg::ADDR_LOCK_BW:   reg_rdata <= lock_bw;
               pps_pkg::ADDR_ACQ_BW:    reg_rdata <= acq_bw;
               pps_pkg::ADDR_LOSS_CFG:  reg_rdata <= loss_cfg;
               pps_pkg::ADDR_WIDE_CFG:  reg_rdata <= wide_cfg;
               pps_pkg::ADDR_STATUS:    reg_rdata <= {5'h00, capture_mode == pps_pkg::PPS_CAPTURE_NEAREST,
                                                      active_bw};
               default:                 reg_rdata <= 8'h00;
            endcase
         end
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Multiplexer decode. Codes 110 and 111 leave the first multiplier unfed; the
   // secondary loop is never offered to it.
   always_comb begin
      case (mux_sel[2:0])
         3'h0:    mux1_src = pps_pkg::PPS_SRC_PRIMARY_ANALOG_FB;
         3'h1:    mux1_src = pps_pkg::PPS_SRC_PRIMARY_DIGITAL_FB;
         3'h2:    mux1_src = rate_src(2'h0);
         3'h3:    mux1_src = rate_src(2'h1);
         3'h4:    mux1_src = rate_src(2'h2);
         3'h5:    mux1_src = rate_src(2'h3);
         default: mux1_src = pps_pkg::PPS_SRC_NONE;
      endcase
      if (mux_sel[pps_pkg::BIT_MUX2_LOWRATE]) begin
         mux2_src = rate_src(mux_sel[5:4]);
      end else begin
         mux2_src = pps_pkg::PPS_SRC_SECONDARY;
      end
   end

   assign sec_freq_code    = sec_freq[2:0];
   assign digital_feedback = (mux_sel[2:0] == 3'h1);

   // Port ratio codes: 0=/1 1=/2 2=/4 3=/6 4=/8 5=/12 6=/16 7=/48 of the first
   // multiplier; codes 8 and up belong to the second multiplier. Barred codes fall to /4.
   always_comb begin
      port1_ratio = port_sel[0][3:0];
      port2_ratio = port_sel[1][3:0];
      if (port1_ratio == 4'h7) begin
         port1_ratio = 4'h2;
      end
      if (port2_ratio == 4'h0 || port2_ratio == 4'h1) begin
         port2_ratio = 4'h2;
      end
   end

   // Lock state and bandwidth selection.
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         lost_q <= 1'b1;
      end else begin
         lost_q <= phase_lost;
      end
   end

   assign phase_lost = (loss_cfg[pps_pkg::BIT_FINE_LOSS_EN] && fine_loss)
                     || (wide_cfg[pps_pkg::BIT_COARSE_LOSS_EN] && coarse_slip)
                     || (loss_cfg[pps_pkg::BIT_LIMIT_LOSS_EN] && at_freq_limit)
                     || (loss_cfg[pps_pkg::BIT_IDLE_LOSS_EN] && input_idle);

   assign active_bw = lost_q ? bw_code(acq_bw) : bw_code(lock_bw);

   always_comb begin
      if (!lost_q && !wide_cfg[pps_pkg::BIT_WIDE_EN]) begin
         capture_mode = pps_pkg::PPS_CAPTURE_NEAREST;
      end else begin
         capture_mode = pps_pkg::PPS_CAPTURE_FULL;
      end
   end

   // Damping table indexed by bandwidth and code.
   always_comb begin
      case (pd_bal[1][2:0])
         3'h1:    damping = pps_pkg::DAMP_1P2;
         3'h2:    damping = pps_pkg::DAMP_2P5;
         3'h4:    damping = (active_bw == pps_pkg::BW_18HZ) ? pps_pkg::DAMP_5
                                                             : pps_pkg::DAMP_10;
         3'h5:    damping = (active_bw == pps_pkg::BW_18HZ) ? pps_pkg::DAMP_5 :
                            (active_bw == pps_pkg::BW_35HZ) ? pps_pkg::DAMP_10
                                                             : pps_pkg::DAMP_20;
         default: damping = pps_pkg::DAMP_5;
      endcase
   end

   // Reference conditioning: divide to 8 kHz when enabled, else halve a 155.52 MHz reference.
   assign in_idx   = (active_input > 3'h6) ? 3'h6 : active_input;
   assign div8k_on = in_cfg[in_idx][pps_pkg::BIT_DIV8K];

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         half_toggle <= 1'b0;
      end else if (ref_edge) begin
         half_toggle <= ~half_toggle;
      end
   end

   pps_div8k #(
      .CW (DIV_W)
   ) u_div8k (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .enable   (div8k_on),
      .edge_in  (ref_edge),
      .ratio    (ref_div_ratio),
      .edge_out (div8k_edge)
   );

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         ref_compare_edge <= 1'b0;
      end else if (div8k_on) begin
         ref_compare_edge <= div8k_edge;
      end else begin
         ref_compare_edge <= ref_edge && (!ref_is_155m || half_toggle);
      end
   end

   // Error selection: wide phase when enabled and used, else pfd_error passed unclamped.
   always_comb begin
      sel_err = pfd_error;
      if (wide_cfg[pps_pkg::BIT_WIDE_EN] && wide_cfg[pps_pkg::BIT_WIDE_USE]) begin
         sel_err = wide_phase;
      end
   end

   pps_avg_filter #(
      .WIDTH (ERR_W),
      .SHIFT (pps_pkg::AVG_SHIFT)
   ) u_avg (
      .sys_clk      (sys_clk),
      .reset_n      (reset_n),
      .sample_valid (err_valid),
      .sample       (sel_err),
      .average      (avg_err)
   );

   assign loop_error    = avg_err;
   assign wide_range_ui = 13'((14'h0001 << wide_cfg[3:0]) - 14'h0001);
endmodule
`default_nettype wire

// ---- include/pps_pkg.sv ----
// Package with register map, field positions, reset values and encodings for the loop path block.
package pps_pkg;
   localparam logic [7:0] ADDR_IN_CFG_FIRST   = 8'h22;
   localparam logic [7:0] ADDR_IN_CFG_LAST    = 8'h28;
   localparam logic [7:0] ADDR_PORT1_SEL      = 8'h61;
   localparam logic [7:0] ADDR_PORT2_SEL      = 8'h62;
   localparam logic [7:0] ADDR_SEC_FREQ       = 8'h64;
   localparam logic [7:0] ADDR_MUX_SEL        = 8'h65;
   localparam logic [7:0] ADDR_LOCK_BW        = 8'h67;
   localparam logic [7:0] ADDR_ACQ_BW         = 8'h69;
   localparam logic [7:0] ADDR_PD_BAL_FIRST   = 8'h6A;
   localparam logic [7:0] ADDR_PD_BAL_LAST    = 8'h6D;
   localparam logic [7:0] ADDR_DAMPING        = 8'h6B;
   localparam logic [7:0] ADDR_LOSS_CFG       = 8'h73;
   localparam logic [7:0] ADDR_WIDE_CFG       = 8'h74;
   localparam logic [7:0] ADDR_STATUS         = 8'h7E;
   localparam int         BIT_DIV8K           = 6;
   localparam int         BIT_MUX2_LOWRATE    = 6;
   localparam int         BIT_WIDE_EN         = 6;
   localparam int         BIT_WIDE_USE        = 5;
   localparam int         BIT_COARSE_LOSS_EN  = 7;
   localparam int         BIT_FINE_LOSS_EN    = 7;
   localparam int         BIT_LIMIT_LOSS_EN   = 6;
   localparam int         BIT_IDLE_LOSS_EN    = 5;
   localparam logic [7:0] RST_MUX_SEL         = 8'h00;
   localparam logic [7:0] RST_SEC_FREQ        = 8'h00;
   localparam logic [7:0] RST_LOCK_BW         = 8'h02;
   localparam logic [7:0] RST_ACQ_BW          = 8'h02;
   localparam logic [7:0] RST_DAMPING         = 8'h03;
   localparam logic [7:0] RST_LOSS_CFG        = 8'hE0;
   localparam logic [7:0] RST_WIDE_CFG        = 8'h00;
   localparam logic [7:0] RST_PD_BAL          = 8'h80;
   localparam logic [7:0] RST_PORT_SEL        = 8'h00;
   localparam logic [7:0] RST_IN_CFG          = 8'h00;
   localparam logic [1:0] BW_18HZ             = 2'h0;
   localparam logic [1:0] BW_35HZ             = 2'h1;
   localparam logic [1:0] BW_70HZ             = 2'h2;
   localparam int         SYS_CLK_HZ          = 100000000;
   localparam int         AVG_FILTER_HZ       = 100;
   localparam int         AVG_SHIFT           = 17;
   localparam int         DIV8K_COUNT         = 12500;
   // Damping factor in tenths, so 12 means 1.2.
   typedef logic [7:0] pps_damp_t;
   localparam pps_damp_t  DAMP_1P2            = 8'h0C;
   localparam pps_damp_t  DAMP_2P5            = 8'h19;
   localparam pps_damp_t  DAMP_5              = 8'h32;
   localparam pps_damp_t  DAMP_10             = 8'h64;
   localparam pps_damp_t  DAMP_20             = 8'hC8;
   typedef enum logic [2:0] {
      PPS_SRC_PRIMARY_ANALOG_FB,
      PPS_SRC_PRIMARY_DIGITAL_FB,
      PPS_SRC_12E1,
      PPS_SRC_16E1,
      PPS_SRC_24DS1,
      PPS_SRC_16DS1,
      PPS_SRC_SECONDARY,
      PPS_SRC_NONE
   } pps_src_e;
   typedef enum logic {
      PPS_CAPTURE_FULL,
      PPS_CAPTURE_NEAREST
   } pps_capture_e;
endpackage

// ---- src/pps_avg_filter.sv ----
// First-order averaging low-pass filter for the comparator phase error.
`timescale 1ns/1ps
`default_nettype none
module pps_avg_filter #(
   parameter int WIDTH = 16,
   parameter int SHIFT = 19
) (
   // Clock and reset.
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   // Sample stream.
   input  wire logic             sample_valid,
   input  wire logic [WIDTH-1:0] sample,
   output logic      [WIDTH-1:0] average
);
   logic signed [WIDTH+SHIFT-1:0] acc;
   logic signed [WIDTH+SHIFT-1:0] next_acc;

   // Leaky integrator: acc += sample - acc/2^SHIFT, corner near 100 Hz at 100 MHz.
   always_comb begin
      next_acc = acc + (WIDTH+SHIFT)'(signed'(sample)) - (acc >>> SHIFT);
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         acc <= '0;
      end else if (sample_valid) begin
         acc <= next_acc;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         average <= '0;
      end else begin
         average <= acc[WIDTH+SHIFT-1:SHIFT];
      end
   end
endmodule
`default_nettype wire

// ---- src/pps_div8k.sv ----
// Divider that reduces an input reference event stream to an 8 kHz event.
`timescale 1ns/1ps
`default_nettype none
module pps_div8k #(
   parameter int CW = 16
) (
   // Clock and reset.
   input  wire logic          sys_clk,
   input  wire logic          reset_n,
   // Control and edges.
   input  wire logic          enable,
   input  wire logic          edge_in,
   input  wire logic [CW-1:0] ratio,
   output logic               edge_out
);
   logic [CW-1:0] count;

   always_ff @(posedge sys_clk) begin
      if (!reset_n || !enable) begin
         count    <= '0;
         edge_out <= 1'b0;
      end else begin
         edge_out <= 1'b0;
         if (edge_in) begin
            if (count >= ratio - CW'(1)) begin
               count    <= '0;
               edge_out <= 1'b1;
            end else begin
               count <= count + CW'(1);
            end
         end
      end
   end
endmodule
`default_nettype wire

// ---- sim/pps_loop_props.sv ----
// Checker for the port behaviour of the loop path control block.
`timescale 1ns/1ps
`default_nettype none
module pps_loop_props (
   // Clock, reset and register port.
   input wire logic                  sys_clk,
   input wire logic                  reset_n,
   input wire logic [7:0]            reg_addr,
   input wire logic [7:0]            reg_wdata,
   input wire logic                  reg_wr,
   input wire logic                  reg_rd,
   input wire logic [7:0]            reg_rdata,
   // Loss sources.
   input wire logic                  fine_loss,
   input wire logic                  coarse_slip,
   input wire logic                  at_freq_limit,
   input wire logic                  input_idle,
   // Loop configuration outputs.
   input wire pps_pkg::pps_src_e     mux1_src,
   input wire pps_pkg::pps_src_e     mux2_src,
   input wire logic                  digital_feedback,
   input wire logic [3:0]            port1_ratio,
   input wire logic [3:0]            port2_ratio,
   input wire pps_pkg::pps_capture_e capture_mode,
   input wire logic [12:0]           wide_range_ui,
   input wire logic                  phase_lost
);
   logic [7:0] wd_q;
   wire logic  mux_wr = reg_wr && reg_addr == pps_pkg::ADDR_MUX_SEL;
   wire logic  wide_wr = reg_wr && reg_addr == pps_pkg::ADDR_WIDE_CFG;
   always_ff @(posedge sys_clk) begin
      wd_q <= reg_wdata;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   chk_mux1_code: assert property (mux_wr && reg_wdata[2:0] < 3'h6 |=> mux1_src == wd_q[2:0])
      else $error("first selector source wrong");
   chk_mux1_nosec: assert property (mux1_src != pps_pkg::PPS_SRC_SECONDARY)
      else $error("first selector took secondary loop");
   chk_mux2_sec: assert property (mux_wr && !reg_wdata[6] |=> mux2_src == pps_pkg::PPS_SRC_SECONDARY)
      else $error("second selector not on secondary loop");
   chk_mux2_rate: assert property (mux_wr && reg_wdata[6] |=> mux2_src == 3'h2 + wd_q[5:4])
      else $error("second selector rate wrong");
   chk_dig_fb: assert property (digital_feedback == (mux1_src == pps_pkg::PPS_SRC_PRIMARY_DIGITAL_FB))
      else $error("feedback kind disagrees with selector");
   chk_port_bar: assert property (port1_ratio != 4'h7 && port2_ratio > 4'h1)
      else $error("barred port ratio seen");
   chk_loss_cause: assert property (phase_lost |-> fine_loss || coarse_slip || at_freq_limit || input_idle)
      else $error("phase loss without a source");
   chk_lost_full: assert property (phase_lost |=> capture_mode == pps_pkg::PPS_CAPTURE_FULL)
      else $error("nearest edge capture while lost");
   chk_wide_ui: assert property (wide_wr |=> wide_range_ui == 13'((32'h1 << wd_q[3:0]) - 32'h1))
      else $error("wide range span wrong");
   cover property (mux_wr && reg_wdata[6]);
   cover property (phase_lost);
   cover property (capture_mode == pps_pkg::PPS_CAPTURE_NEAREST);
endmodule
`default_nettype wire

// ---- sim/pps_loop_ctrl_tb_top.sv ----
// Self-checking testbench for the loop path control block.
`timescale 1ns/1ps
`default_nettype none
module pps_loop_ctrl_tb_top;
   logic                  sys_clk = 1'b0;
   logic                  reset_n = 1'b0;
   logic [7:0]            reg_addr = 8'h00;
   logic [7:0]            reg_wdata = 8'h00;
   logic                  reg_wr = 1'b0;
   logic                  reg_rd = 1'b0;
   logic [7:0]            reg_rdata;
   logic [2:0]            active_input = 3'h0;
   logic                  ref_edge = 1'b0;
   logic                  ref_is_155m = 1'b0;
   logic [15:0]           ref_div_ratio = 16'h0004;
   // Loss sources: fine, coarse, limit, idle; fine starts active.
   logic [3:0]            loss = 4'h1;
   logic                  err_valid = 1'b0;
   logic [15:0]           loop_error;
   pps_pkg::pps_src_e     mux1_src;
   pps_pkg::pps_src_e     mux2_src;
   logic [2:0]            sec_freq_code;
   logic                  digital_feedback;
   logic [3:0]            port1_ratio;
   logic [3:0]            port2_ratio;
   logic [1:0]            active_bw;
   pps_pkg::pps_damp_t    damping;
   pps_pkg::pps_capture_e capture_mode;
   logic                  ref_compare_edge;
   logic [12:0]           wide_range_ui;
   logic                  phase_lost;
   int                    failures = 0;
   int                    tests_run = 0;
   int                    pulses = 0;
   pps_loop_ctrl pps_loop_ctrl_inst (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .active_input, .ref_edge, .ref_is_155m, .ref_div_ratio,
      .err_valid, .pfd_error(16'h4000), .wide_phase(16'hC000), .fine_loss(loss[0]),
      .coarse_slip(loss[1]), .at_freq_limit(loss[2]), .input_idle(loss[3]), .mux1_src,
      .mux2_src, .sec_freq_code, .digital_feedback, .port1_ratio, .port2_ratio, .active_bw,
      .damping, .capture_mode, .ref_compare_edge, .loop_error, .wide_range_ui, .phase_lost);
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (ref_compare_edge === 1'b1) pulses++;
   end
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", name, exp, got);
         failures++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(name, exp, reg_rdata);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic send_edges(input int n, input int exp);
      pulses = 0;
      repeat (n) begin
         @(posedge sys_clk);
         ref_edge <= 1'b1;
         @(posedge sys_clk);
         ref_edge <= 1'b0;
         repeat (2) @(posedge sys_clk);
      end
      wait_n(4);
      chk("compare_pulses", 16'(exp), 16'(pulses));
   endtask
   function automatic logic [7:0] exp_damp(input int b, input int c);
      case (c)
         1: return pps_pkg::DAMP_1P2;
         2: return pps_pkg::DAMP_2P5;
         4: return (b == 0) ? pps_pkg::DAMP_5 : pps_pkg::DAMP_10;
         5: return (b == 0) ? pps_pkg::DAMP_5 : (b == 1) ? pps_pkg::DAMP_10 : pps_pkg::DAMP_20;
         default: return pps_pkg::DAMP_5;
      endcase
   endfunction
   task automatic t_reset;
      chk("mux1_src", pps_pkg::PPS_SRC_PRIMARY_ANALOG_FB, mux1_src);
      chk("digital_feedback", 16'h0000, digital_feedback);
      chk("mux2_src", pps_pkg::PPS_SRC_SECONDARY, mux2_src);
      chk("active_bw", pps_pkg::BW_70HZ, active_bw);
      chk("damping", pps_pkg::DAMP_5, damping);
      chk("capture_mode", pps_pkg::PPS_CAPTURE_FULL, capture_mode);
      rchk("mux_reg", pps_pkg::ADDR_MUX_SEL, pps_pkg::RST_MUX_SEL);
      rchk("wide_reg", pps_pkg::ADDR_WIDE_CFG, pps_pkg::RST_WIDE_CFG);
      rchk("freq_reg", pps_pkg::ADDR_SEC_FREQ, pps_pkg::RST_SEC_FREQ);
      rchk("bal_reg", pps_pkg::ADDR_PD_BAL_FIRST, pps_pkg::RST_PD_BAL);
   endtask
   task automatic t_edges;
      ref_is_155m <= 1'b1;
      send_edges(8, 4);
      ref_is_155m <= 1'b0;
      wr(pps_pkg::ADDR_IN_CFG_FIRST, 8'h40);
      send_edges(8, 2);
      wr(pps_pkg::ADDR_IN_CFG_FIRST, 8'h00);
   endtask
   task automatic t_mux;
      wr(pps_pkg::ADDR_SEC_FREQ, 8'h05);
      chk("sec_freq_code", 16'h0005, sec_freq_code);
      for (int i = 0; i < 4; i++) begin
         wr(pps_pkg::ADDR_MUX_SEL, 8'(8'h40 | (i << 4) | (i + 2)));
         chk("mux2_src", 16'(i + 2), mux2_src);
         chk("mux1_src", 16'(i + 2), mux1_src);
      end
      for (int c = 0; c < 8; c++) begin
         wr(pps_pkg::ADDR_MUX_SEL, 8'(c));
         chk("mux2_src", pps_pkg::PPS_SRC_SECONDARY, mux2_src);
         chk("mux1_src", (c < 6) ? 16'(c) : 16'(pps_pkg::PPS_SRC_NONE), mux1_src);
         chk("digital_feedback", 16'(c == 1), digital_feedback);
      end
      rchk("mux_reg", pps_pkg::ADDR_MUX_SEL, 8'h07);
   endtask
   task automatic t_ports;
      for (int c = 0; c < 8; c++) begin
         wr(pps_pkg::ADDR_PORT1_SEL, 8'(c));
         wr(pps_pkg::ADDR_PORT2_SEL, 8'(c));
         chk("port1_ratio", (c == 7) ? 16'h0002 : 16'(c), port1_ratio);
         chk("port2_ratio", (c < 2) ? 16'h0002 : 16'(c), port2_ratio);
      end
   endtask
   task automatic t_damp;
      for (int b = 0; b < 3; b++) begin
         wr(pps_pkg::ADDR_ACQ_BW, 8'(b));
         for (int c = 1; c < 6; c++) begin
            wr(pps_pkg::ADDR_DAMPING, 8'(c));
            chk("active_bw", 16'(b), active_bw);
            chk("damping", exp_damp(b, c), damping);
         end
      end
   endtask
   task automatic t_lock;
      wr(pps_pkg::ADDR_LOCK_BW, pps_pkg::BW_18HZ);
      wr(pps_pkg::ADDR_ACQ_BW, pps_pkg::BW_35HZ);
      chk("active_bw", pps_pkg::BW_35HZ, active_bw);
      @(posedge sys_clk);
      loss <= 4'h0;
      wait_n(3);
      chk("active_bw", pps_pkg::BW_18HZ, active_bw);
      chk("capture_mode", pps_pkg::PPS_CAPTURE_NEAREST, capture_mode);
      wr(pps_pkg::ADDR_WIDE_CFG, 8'h40);
      wait_n(2);
      chk("capture_mode", pps_pkg::PPS_CAPTURE_FULL, capture_mode);
      wr(pps_pkg::ADDR_WIDE_CFG, 8'h80);
      for (int s = 0; s < 4; s++) begin
         @(posedge sys_clk);
         loss <= 4'(1 << s);
         wait_n(1);
         chk("phase_lost", 16'h0001, phase_lost);
         if (s == 1) wr(pps_pkg::ADDR_WIDE_CFG, 8'h00);
         else wr(pps_pkg::ADDR_LOSS_CFG, 8'hE0 & ~(8'h80 >> ((s == 0) ? 0 : s - 1)));
         chk("phase_lost", 16'h0000, phase_lost);
         wr(pps_pkg::ADDR_LOSS_CFG, 8'hE0);
         wr(pps_pkg::ADDR_WIDE_CFG, 8'h80);
         loss <= 4'h0;
      end
   endtask
   task automatic t_filter;
      err_valid <= 1'b1;
      wait_n(64);
      chk("loop_error", 16'h0000, 16'(loop_error[15]));
      wr(pps_pkg::ADDR_WIDE_CFG, 8'h60);
      wait_n(128);
      chk("loop_error", 16'h0001, 16'(loop_error[15]));
   endtask
   task automatic t_wide;
      int codes[5] = '{0, 1, 12, 13, 15};
      foreach (codes[k]) begin
         wr(pps_pkg::ADDR_WIDE_CFG, 8'(codes[k]));
         chk("wide_range_ui", (codes[k] > 12) ? 16'h1FFF : 16'((1 << codes[k]) - 1),
             wide_range_ui);
      end
      rchk("wide_reg", pps_pkg::ADDR_WIDE_CFG, 8'h0F);
      wr(8'h50, 8'hA5);
      rchk("unmapped", 8'h50, 8'h00);
   endtask
   task automatic wrap_up;
      if (failures == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      wait_n(1);
      t_reset;
      t_edges;
      t_mux;
      t_ports;
      t_damp;
      t_lock;
      t_filter;
      t_wide;
      wrap_up;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      wrap_up;
   end
endmodule
bind pps_loop_ctrl pps_loop_props pps_loop_props_inst (.sys_clk, .reset_n, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fine_loss, .coarse_slip, .at_freq_limit,
   .input_idle, .mux1_src, .mux2_src, .digital_feedback, .port1_ratio, .port2_ratio,
   .capture_mode, .wide_range_ui, .phase_lost);
`default_nettype wire
